// ==== servo_diag_parameter_map.sv ====
`timescale 1ns/1ps
`include "servo_diag_regs.svh"

// Function
// - locked parameters refuse writes while drive enabled; accepted while disabled.
// - restart-effective parameter stores new value; old stays in use until power cycle, while sys_rst alone loads the default.
// - volatile parameters return to defaults at power-up, not kept.
// - firmware version is read-only 16-bit word in decimal form.
// - in fault state, fault-code word reports active fault code, 16 bits.
// - writing 0 to fault-code word clears fault like alarm reset input.
// - fault code held in hex, presented as bcd digits.
// - speed input offset, default 0 mV, applies only in speed mode.
// - torque input offset, default 0 mV, applies only in torque mode.
// - two monitor drift trims reset to 0 mV, usable in all modes.
module servo_diag_parameter_map #(
    parameter logic [15:0] FIRMWARE_VERSION_BIN = 16'h0064  // arbitrary value
) (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          power_up,
    input  wire logic                          param_wr,
    input  wire logic                          param_rd,
    input  wire logic [7:0]                    param_addr,
    input  wire logic [15:0]                   param_wdata,
    output logic      [15:0]                   param_rdata,
    output logic                               param_ack,
    output logic                               param_refused,
    input  wire logic                          drive_enabled,
    input  wire servo_diag_pkg::control_mode_t control_mode,
    input  wire logic                          fault_set,
    input  wire logic [15:0]                   fault_code_in,
    input  wire logic                          alarm_reset_input,
    output logic                               fault_active,
    output logic                               fault_clear,
    output logic      [15:0]                   speed_offset_applied,
    output logic      [15:0]                   torque_offset_applied,
    output logic      [15:0]                   monitor_one_drift_trim,
    output logic      [15:0]                   monitor_two_drift_trim,
    output logic      [15:0]                   adjust_function,
    output logic      [15:0]                   restart_param_active
);
    import servo_diag_pkg::*;

    // pin inputs pass two flops
    logic        en_meta, en_sync, alarm_reset_input_meta, alarm_reset_input_sync, alarm_reset_input_prev;
    logic [15:0] fault_code;
    logic [15:0] speed_input_offset, torque_input_offset;
    logic [15:0] restart_param_stored;
    logic [15:0] version_bcd, fault_bcd;

    wire hit_version = param_addr == `ADDR_FIRMWARE_VERSION;
    wire hit_fault   = param_addr == `ADDR_ACTIVE_FAULT_CODE;
    wire hit_adjust  = param_addr == `ADDR_ADJUST_FUNCTION;
    wire hit_monitor_channel_one    = param_addr == `ADDR_MONITOR_ONE_TRIM;
    wire hit_monitor_channel_two    = param_addr == `ADDR_MONITOR_TWO_TRIM;
    wire hit_soff    = param_addr == `ADDR_SPEED_INPUT_OFFSET;
    wire hit_toff    = param_addr == `ADDR_TORQUE_INPUT_OFFSET;
    wire hit_restart = param_addr == `ADDR_RESTART_PARAM;
    wire hit_any     = hit_version | hit_fault | hit_adjust | hit_monitor_channel_one | hit_monitor_channel_two
                     | hit_soff | hit_toff | hit_restart;

    // locked parameter only writable with drive disabled
    wire lock_block   = hit_adjust & en_sync;
    wire wr_refused   = param_wr & (hit_version | lock_block | !hit_any
                      | (hit_fault & param_wdata != `FAULT_CLEAR_VALUE));
    wire wr_ok        = param_wr & !wr_refused;
    wire host_clear   = wr_ok & hit_fault;
    wire alarm_reset_input_rise    = alarm_reset_input_sync & !alarm_reset_input_prev;
    wire clear_event  = host_clear | alarm_reset_input_rise;

    bcd_convert u_version_bcd (
        .bin_value (FIRMWARE_VERSION_BIN),
        .bcd_value (version_bcd)
    );
    bcd_convert u_fault_bcd (
        .bin_value (fault_code),
        .bcd_value (fault_bcd)
    );

    wire [15:0] rd_mux =
        hit_version ? version_bcd :
        hit_fault   ? (fault_active ? fault_bcd : 16'h0000) :
        hit_adjust  ? adjust_function :
        hit_monitor_channel_one    ? monitor_one_drift_trim :
        hit_monitor_channel_two    ? monitor_two_drift_trim :
        hit_soff    ? speed_input_offset :
        hit_toff    ? torque_input_offset :
        hit_restart ? restart_param_stored : 16'h0000;

    always_ff @(posedge clk) begin
        en_meta   <= drive_enabled;
        en_sync   <= en_meta;
        alarm_reset_input_meta <= alarm_reset_input;
        alarm_reset_input_sync <= alarm_reset_input_meta;
        alarm_reset_input_prev <= alarm_reset_input_sync;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            param_rdata   <= 16'h0000;
            param_ack     <= 1'b0;
            param_refused <= 1'b0;
        end else begin
            param_ack     <= param_wr | param_rd;
            param_refused <= wr_refused;
            if (param_rd) param_rdata <= rd_mux;
        end
    end

    // fault: new fault wins over clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_active <= 1'b0;
            fault_code   <= 16'h0000;
            fault_clear  <= 1'b0;
        end else begin
            fault_clear <= clear_event;
            if (fault_set) begin
                fault_active <= 1'b1;
                fault_code   <= fault_code_in;
            end else if (clear_event) begin
                fault_active <= 1'b0;
                fault_code   <= 16'h0000;
            end
        end
    end

    // volatile parameters: defaults on every power-up
    always_ff @(posedge clk) begin
        if (sys_rst || power_up) begin
            adjust_function        <= `DEFAULT_ADJUST;
            monitor_one_drift_trim <= `DEFAULT_TRIM;
            monitor_two_drift_trim <= `DEFAULT_TRIM;
            speed_input_offset     <= `DEFAULT_OFFSET;
            torque_input_offset    <= `DEFAULT_OFFSET;
        end else if (wr_ok) begin
            if (hit_adjust) adjust_function <= param_wdata;
            if (hit_monitor_channel_one)   monitor_one_drift_trim <= param_wdata;
            if (hit_monitor_channel_two)   monitor_two_drift_trim <= param_wdata;
            if (hit_soff)   speed_input_offset <= param_wdata;
            if (hit_toff)   torque_input_offset <= param_wdata;
        end
    end

    // restart-effective: stored copy survives sys_rst, active copy loads on power-up
    always_ff @(posedge clk) begin
        if (power_up) begin
            restart_param_active <= restart_param_stored;
        end else if (sys_rst) begin
            restart_param_active <= `DEFAULT_RESTART_PARAM;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst && power_up) begin
            restart_param_stored <= `DEFAULT_RESTART_PARAM;
        end else if (wr_ok && hit_restart) begin
            restart_param_stored <= param_wdata;
        end
    end

    // offsets gated by mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            speed_offset_applied  <= 16'h0000;
            torque_offset_applied <= 16'h0000;
        end else begin
            speed_offset_applied  <= (control_mode == speed_control_mode)
                                   ? speed_input_offset : 16'h0000;
            torque_offset_applied <= (control_mode == torque_control_mode)
                                   ? torque_input_offset : 16'h0000;
        end
    end
endmodule // servo_diag_parameter_map

// ==== servo_diag_regs.svh ====
`ifndef SERVO_DIAG_REGS_SVH
`define SERVO_DIAG_REGS_SVH

// word addresses on the parameter access port
`define ADDR_FIRMWARE_VERSION     8'h00
`define ADDR_ACTIVE_FAULT_CODE    8'h02
`define ADDR_ADJUST_FUNCTION      8'h10
`define ADDR_MONITOR_ONE_TRIM     8'h14
`define ADDR_MONITOR_TWO_TRIM     8'h15
`define ADDR_SPEED_INPUT_OFFSET   8'h16
`define ADDR_TORQUE_INPUT_OFFSET  8'h17
`define ADDR_RESTART_PARAM        8'h18

// defaults
`define DEFAULT_TRIM              16'h0000
`define DEFAULT_OFFSET            16'h0000
`define DEFAULT_ADJUST            16'h0000
`define DEFAULT_RESTART_PARAM     16'h007f
`define FAULT_CLEAR_VALUE         16'h0000

`endif

// ==== servo_diag_pkg.sv ====
package servo_diag_pkg;
    typedef enum logic [1:0] {
        position_control_mode = 2'b00,
        speed_control_mode    = 2'b01,
        torque_control_mode   = 2'b11
    } control_mode_t;
endpackage

// ==== bcd_convert.sv ====
`timescale 1ns/1ps
// combinational binary to four-digit bcd, double dabble
module bcd_convert (
    input  wire logic [15:0] bin_value,
    output logic      [15:0] bcd_value
);
    logic [31:0] work;
    integer      i;

    always_comb begin
        work = {16'h0000, bin_value};
        for (i = 0; i < 16; i = i + 1) begin
            if (work[19:16] > 4'h4) work[19:16] = work[19:16] + 4'h3;
            if (work[23:20] > 4'h4) work[23:20] = work[23:20] + 4'h3;
            if (work[27:24] > 4'h4) work[27:24] = work[27:24] + 4'h3;
            if (work[31:28] > 4'h4) work[31:28] = work[31:28] + 4'h3;
            work = {work[30:0], 1'b0};
        end
        // values above 9999 lose the fifth digit, leaving the value modulo 10000; fault codes stay far below
        bcd_value = work[31:16];
    end
endmodule // bcd_convert

// ==== servo_diag_parameter_map_assertions.sv ====
`timescale 1ns/1ps
module servo_diag_checker
    import servo_diag_pkg::*;
(
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire logic          power_up,
    input wire logic          param_wr,
    input wire logic [7:0]    param_addr,
    input wire logic [15:0]   param_wdata,
    input wire logic          param_refused,
    input wire logic          drive_enabled,
    input wire control_mode_t control_mode,
    input wire logic          fault_set,
    input wire logic          fault_active,
    input wire logic          fault_clear,
    input wire logic [15:0]   speed_offset_applied,
    input wire logic [15:0]   torque_offset_applied,
    input wire logic [15:0]   restart_param_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // three samples cover the two-flop synchroniser on the enable pin
    sequence lock_held; drive_enabled [*3]; endsequence
    sequence clear_req; param_wr && param_addr == 8'h02 && param_wdata == 16'h0000; endsequence
    chk_lock_refuses_write: assert property (lock_held ##0 (param_wr && param_addr == 8'h10)
        |=> param_refused) else $error("locked write accepted");
    chk_version_read_only: assert property (param_wr && param_addr == 8'h00 |=> param_refused)
        else $error("version write accepted");
    chk_fault_nonzero_refused: assert property (param_wr && param_addr == 8'h02
        && param_wdata != 16'h0000 |=> param_refused) else $error("nonzero fault write taken");
    chk_fault_write_clears: assert property (clear_req ##0 !fault_set
        |=> fault_clear && !fault_active) else $error("zero write did not clear");
    chk_fault_raised: assert property (fault_set |=> fault_active)
        else $error("fault not raised");
    chk_speed_offset_gated: assert property (control_mode != speed_control_mode
        |=> speed_offset_applied == 16'h0000) else $error("speed offset outside speed mode");
    chk_torque_offset_gated: assert property (control_mode != torque_control_mode
        |=> torque_offset_applied == 16'h0000) else $error("torque offset outside torque mode");
    chk_refuse_needs_write: assert property (param_refused |-> $past(param_wr))
        else $error("refusal without write");
    chk_restart_value_held: assert property (!power_up |=> restart_param_active
        == $past(restart_param_active)) else $error("restart value changed without power cycle");
endmodule // servo_diag_checker

bind servo_diag_parameter_map servo_diag_checker chk (.clk(clk), .sys_rst(sys_rst),
    .param_wr(param_wr), .param_addr(param_addr), .param_wdata(param_wdata),
    .param_refused(param_refused), .drive_enabled(drive_enabled), .control_mode(control_mode),
    .fault_set(fault_set), .fault_active(fault_active), .fault_clear(fault_clear),
    .speed_offset_applied(speed_offset_applied), .torque_offset_applied(torque_offset_applied),
    .power_up(power_up), .restart_param_active(restart_param_active));

// ==== servo_host_model.sv ====
`timescale 1ns/1ps
module servo_host_model (
    input  wire logic        clk,
    input  wire logic        param_ack,
    input  wire logic        param_refused,
    input  wire logic [15:0] param_rdata,
    output logic             param_wr = 1'b0,
    output logic             param_rd = 1'b0,
    output logic      [7:0]  param_addr = 8'h00,
    output logic      [15:0] param_wdata = 16'h0000
);
    logic        got_ack;
    logic        got_refused;
    logic [15:0] got_rdata;
    // one strobe cycle, answer taken half a cycle after the taking edge
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        param_wr = w;
        param_rd = !w;
        param_addr = a;
        param_wdata = d;
        @(negedge clk);
        param_wr = 1'b0;
        param_rd = 1'b0;
        got_ack = param_ack;
        got_refused = param_refused;
        got_rdata = param_rdata;
    endtask
endmodule // servo_host_model

// ==== servo_diag_parameter_map_tb.sv ====
`timescale 1ns/1ps
module servo_diag_parameter_map_tb;
    import servo_diag_pkg::*;
    logic clk = 0, sys_rst = 1, power_up = 1, drive_enabled = 0, fault_set = 0;
    logic alarm_reset_input = 0, param_wr, param_rd, param_ack, param_refused;
    logic fault_active, fault_clear;
    logic [7:0] param_addr;
    logic [15:0] fault_code_in = 16'h0000, param_wdata, param_rdata, speed_off, torque_off;
    logic [15:0] trim_one, trim_two, adjust_function, restart_active;
    control_mode_t control_mode = position_control_mode;
    control_mode_t modes [3] = '{position_control_mode, speed_control_mode, torque_control_mode};
    int errors = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    servo_diag_parameter_map #(.FIRMWARE_VERSION_BIN(16'h04d2)) dut (.clk(clk),
        .sys_rst(sys_rst), .power_up(power_up), .param_wr(param_wr), .param_rd(param_rd),
        .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
        .param_ack(param_ack), .param_refused(param_refused), .drive_enabled(drive_enabled),
        .control_mode(control_mode), .fault_set(fault_set), .fault_code_in(fault_code_in),
        .alarm_reset_input(alarm_reset_input), .fault_active(fault_active),
        .fault_clear(fault_clear), .speed_offset_applied(speed_off),
        .torque_offset_applied(torque_off), .monitor_one_drift_trim(trim_one),
        .monitor_two_drift_trim(trim_two), .adjust_function(adjust_function),
        .restart_param_active(restart_active));
    servo_host_model host (.clk(clk), .param_ack(param_ack), .param_refused(param_refused),
        .param_rdata(param_rdata), .param_wr(param_wr), .param_rd(param_rd),
        .param_addr(param_addr), .param_wdata(param_wdata));
    task check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d, input logic refuse);
        host.access(1'b1, a, d);
        check("ack", 16'h0001, {15'h0, host.got_ack});
        check("refused", {15'h0, refuse}, {15'h0, host.got_refused});
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        host.access(1'b0, a, 16'h0000);
        check(name, exp, host.got_rdata);
    endtask
    task raise(input logic [15:0] code);
        @(negedge clk);
        fault_set = 1;
        fault_code_in = code;
        @(negedge clk);
        fault_set = 0;
    endtask
    task complete_run;
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        complete_run;
    end
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 0;
        power_up = 0;
        check("restart_rst", 16'h007f, restart_active);
        check("trim_rst", 16'h0000, trim_one);
        rd(8'h18, 16'h007f, "restart_stored");
        rd(8'h00, 16'h1234, "version");
        wr(8'h00, 16'h5555, 1);
        rd(8'h00, 16'h1234, "version_kept");
        rd(8'h02, 16'h0000, "no_fault");
        raise(16'h0017);
        rd(8'h02, 16'h0023, "fault_bcd");
        wr(8'h02, 16'h0001, 1);
        check("still_faulted", 16'h0001, {15'h0, fault_active});
        wr(8'h02, 16'h0000, 0);
        check("write_cleared", 16'h0000, {15'h0, fault_active});
        check("clear_pulse", 16'h0001, {15'h0, fault_clear});
        raise(16'h0063);
        rd(8'h02, 16'h0099, "fault_bcd99");
        alarm_reset_input = 1;
        repeat (4) @(negedge clk);
        check("pin_cleared", 16'h0000, {15'h0, fault_active});
        alarm_reset_input = 0;
        drive_enabled = 1;
        repeat (3) @(negedge clk);
        wr(8'h10, 16'h00a5, 1);
        check("adjust_locked", 16'h0000, adjust_function);
        drive_enabled = 0;
        repeat (3) @(negedge clk);
        wr(8'h10, 16'h00a5, 0);
        check("adjust_set", 16'h00a5, adjust_function);
        wr(8'h14, 16'h0011, 0);
        wr(8'h15, 16'h0022, 0);
        wr(8'h16, 16'h0005, 0);
        wr(8'h17, 16'h0009, 0);
        check("trim_one", 16'h0011, trim_one);
        for (int i = 0; i < 3; i++) begin
            control_mode = modes[i];
            repeat (2) @(negedge clk);
            check("speed_off", modes[i] == speed_control_mode ? 16'h5 : 16'h0, speed_off);
            check("torque_off", modes[i] == torque_control_mode ? 16'h9 : 16'h0, torque_off);
            check("trim_two", 16'h0022, trim_two);
        end
        wr(8'h18, 16'h0011, 0);
        check("restart_old", 16'h007f, restart_active);
        wr(8'h30, 16'h1111, 1);
        power_up = 1;
        @(negedge clk);
        power_up = 0;
        @(negedge clk);
        check("restart_new", 16'h0011, restart_active);
        check("trim_lost", 16'h0000, trim_one);
        check("adjust_lost", 16'h0000, adjust_function);
        complete_run;
    end
endmodule // servo_diag_parameter_map_tb
